// File: ctsync_defines.svh
`ifndef CTSYNC_DEFINES_SVH
`define CTSYNC_DEFINES_SVH
// ==========================================================
// Register byte offsets
`define CTS_OFF_ENABLE    8'h00
`define CTS_OFF_TX_MULTIPLEX_SELECT     8'h04
`define CTS_OFF_RX_MULTIPLEX_SELECT     8'h08
`define CTS_OFF_RECOVERY  8'h0C
`define CTS_OFF_CAUSE     8'h10
`define CTS_OFF_MASK      8'h14
`define CTS_OFF_RESYNC    8'h18
`define CTS_OFF_ROLE      8'h1C
`define CTS_OFF_BURST     8'h20
`define CTS_OFF_DELAY     8'h24
// ==========================================================
// Field encodings and positions
`define CTS_MUX_MUX1      2'h0
`define CTS_MUX_MUX2      2'h2
`define CTS_MUX_MUX3      2'h3
`define CTS_MUX_CLEAR     8'h03
`define CTS_FMT_ON        2'h3
`define CTS_EN_FMT_LO     2
`define CTS_EN_FRAME      4
`define CTS_RC_ENABLE     0
`define CTS_RC_SLOW       1
`define CTS_RC_TRIPLE     2
`define CTS_RC_LOWSPD     6
`define CTS_RC_SYNCED     7
`define CTS_RX_MULTIPLEX_SELECT_TOL     3
`define CTS_CAUSE_FOUND   0
`define CTS_CAUSE_SYNERR  3
// ==========================================================
// Timing (ps, clock 5000 ps)
`define CTS_CLK_PS        5000
`define CTS_FAST_STEP_PS  651000
`define CTS_SLOW_STEP_PS  108000
`define CTS_TRIPLE_PS     1700000
`define CTS_TARGET_PS     6900000
`define CTS_BIT_CYC       12'd2778
`define CTS_PREAMBLE2     10
`define CTS_PREAMBLE3     12
`define CTS_MARK_BITS     24
`define CTS_FRAME_BITS    12'd144
`define CTS_SEARCH_MASK   24'hFFFFFF
`endif

// File: ctsync_pkg.sv
`default_nettype none
package ctsync_pkg;
    typedef enum logic [1:0] {CTS_HUNT, CTS_LOCKED, CTS_CLEAR} ctsync_state_t;
endpackage
`default_nettype wire

// File: ctsync_dpll.sv
`include "ctsync_defines.svh"
`default_nettype none
module ctsync_dpll
    import ctsync_pkg::*;
#(
    parameter logic [11:0] BIT_CYC = `CTS_BIT_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Control
    input  wire logic        track_en,
    input  wire logic        slow,
    input  wire logic        triple,
    input  wire logic        clear,
    input  wire logic        rx_data,
    // Results
    output logic             bit_strobe,
    output logic             bit_value
);
    // Nominal bit length in ps; every timing figure scales with BIT_CYC so a
    // shortened bit keeps the sample points inside the bit
    localparam longint NOM_PS = longint'(`CTS_CLK_PS) * longint'(`CTS_BIT_CYC);

    function automatic logic [11:0] scale_cyc(input longint ps);
        longint c;
        c = ps * longint'(BIT_CYC) / NOM_PS;
        if (c < 1)
            c = 1;
        scale_cyc = 12'(c);
    endfunction

    localparam logic [11:0] FAST_STEP = scale_cyc(`CTS_FAST_STEP_PS);
    localparam logic [11:0] SLOW_STEP = scale_cyc(`CTS_SLOW_STEP_PS);
    localparam logic [11:0] HALF_SEP  = scale_cyc(`CTS_TRIPLE_PS / 2);
    localparam logic [11:0] TARGET    = scale_cyc(`CTS_TARGET_PS);
    logic [11:0] phase_r;
    logic        prev_r;
    logic [1:0]  votes_r;
    logic        early_r;
    logic [11:0] step;
    logic [11:0] err;
    // ==========================================================
    // Phase counter: edges pull the bit boundary, sample sits at TARGET
    assign step = slow ? SLOW_STEP : FAST_STEP;
    assign err  = (phase_r > (BIT_CYC >> 1)) ? (BIT_CYC - phase_r) : phase_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_r <= 12'h000;
        end else if (clear) begin
            phase_r <= 12'h000;
        end else if (track_en && rx_data != prev_r) begin
            if (phase_r > (BIT_CYC >> 1))
                phase_r <= (err > step) ? phase_r + step : 12'h000;
            else
                phase_r <= (err > step) ? phase_r - step : 12'h000;
        end else if (phase_r == BIT_CYC - 12'h001) begin
            phase_r <= 12'h000;
        end else begin
            phase_r <= phase_r + 12'h001;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) prev_r <= 1'b0;
        else     prev_r <= rx_data;
    end
    // ==========================================================
    // One or three samples around the predicted middle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            votes_r <= 2'h0;
            early_r <= 1'b0;
        end else if (phase_r == TARGET - HALF_SEP) begin
            early_r <= rx_data;
        end else if (phase_r == TARGET) begin
            votes_r <= 2'(early_r) + 2'(rx_data);
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_strobe <= 1'b0;
            bit_value  <= 1'b0;
        end else begin
            bit_strobe <= (phase_r == TARGET + HALF_SEP);
            if (phase_r == TARGET + HALF_SEP)
                bit_value <= triple ? (votes_r + 2'(rx_data) >= 2'h2) : votes_r[0] ^ early_r;
        end
    end
endmodule
`default_nettype wire

// File: ctsync_top.sv
// Functional notes
// - Base call: both muxes MUX2, follow reference
// - Base MUX3 receive decouples from reference
// - Receive MUX2 recouples to reference
// - Base tracking moves radio timing only in MUX3 receive
// - Handset adjusts timing only while receiving
// - MUX3 swaps timing master and slave
// - Two-speed loop, 651 and 108 ns steps
// - Low speed after marker, bit1 forces
// - Bit2 selects single or triple sampling
// - Handset recovery moves sample and radio timing
// - Base without recovery samples fixed middle
// - MUX3 receive forces recovery in base role only
// - Base optionally slaves to burst reference
// - SYN preamble plus 24-bit marker pattern
// - RX mux field picks pattern, role and MUX3 receive set polarity
// - Search pattern, record maskable found cause
// - Missed pattern after lock raises sync error
// - Resync command reseeks and stops transmit
// - RX_MULTIPLEX_SELECT bit3 tolerates one bit error
// - Both muxes 03 hex means clear mode
// - MUX1 transmit blocked until synchronized
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`include "ctsync_defines.svh"
`default_nettype none
module ctsync_top
    import ctsync_pkg::*;
#(
    parameter logic [23:0] MARKER_BASE    = 24'hBEE4A1,
    parameter logic [23:0] ALIGN_BASE     = 24'h3E4E5F,
    parameter logic [11:0] BIT_CYC        = `CTS_BIT_CYC
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // AXI4-Lite write
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    // AXI4-Lite read
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    // Link
    input  wire logic        RX_DATA,
    input  wire logic        BURST_REF_PULSE,
    // Status
    output logic             TX_ALLOW,
    output logic             RADIO_TIMING_FROM_LOOP,
    output logic             REF_COUPLED,
    output logic             MARKER_IRQ
);
    logic [7:0]  enable_r;
    logic [7:0]  tx_multiplex_select_r;
    logic [7:0]  rx_multiplex_select_r;
    logic [7:0]  recov_r;
    logic [7:0]  cause_r;
    logic [7:0]  mask_r;
    logic [7:0]  role_r;
    logic [7:0]  burst_r;
    logic [7:0]  delay_r;
    logic        aw_got_r;
    logic        w_got_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        wr_fire;
    logic        resync_cmd;
    logic        clear_mode;
    logic        handset;
    logic        mux3_rx;
    ctsync_state_t state_r;
    logic [23:0] shift_r;
    logic [11:0] bit_in_frame_r;
    logic        found_r;
    logic [23:0] pattern;
    logic        match;
    logic        bit_strobe;
    logic        bit_value;
    logic        track_en;

    function automatic logic [7:0] lane(input logic [7:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
        lane = s[0] ? d[7:0] : old;
    endfunction

    function automatic logic [4:0] ones24(input logic [23:0] v);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < 24; i++)
            n = n + 5'(v[i]);
        ones24 = n;
    endfunction

    // ==========================================================
    // Write channel: address and data taken in any order
    assign AWREADY = !aw_got_r && !BVALID;
    assign WREADY  = !w_got_r && !BVALID;
    assign wr_fire = aw_got_r && w_got_r && !BVALID;
    assign BRESP   = 2'h0;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
            BVALID   <= 1'b0;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_got_r <= 1'b1;
                awaddr_r <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_got_r <= 1'b1;
                wdata_r <= WDATA;
                wstrb_r <= WSTRB;
            end
            if (wr_fire) begin
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
                BVALID   <= 1'b1;
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end
    assign resync_cmd = wr_fire && awaddr_r == `CTS_OFF_RESYNC;

    // ==========================================================
    // Control registers
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            enable_r <= 8'h00;
            tx_multiplex_select_r  <= `CTS_MUX_CLEAR;
            rx_multiplex_select_r  <= `CTS_MUX_CLEAR;
            recov_r  <= 8'h00;
            mask_r   <= 8'h00;
            role_r   <= 8'h00;
            burst_r  <= 8'h00;
            delay_r  <= 8'h00;
        end else if (wr_fire) begin
            case (awaddr_r)
                `CTS_OFF_ENABLE:   enable_r <= lane(enable_r, wdata_r, wstrb_r);
                `CTS_OFF_TX_MULTIPLEX_SELECT:    tx_multiplex_select_r  <= lane(tx_multiplex_select_r, wdata_r, wstrb_r);
                `CTS_OFF_RX_MULTIPLEX_SELECT:    rx_multiplex_select_r  <= lane(rx_multiplex_select_r, wdata_r, wstrb_r);
                `CTS_OFF_RECOVERY: recov_r  <= lane(recov_r, wdata_r, wstrb_r) & 8'h07;
                `CTS_OFF_MASK:     mask_r   <= lane(mask_r, wdata_r, wstrb_r);
                `CTS_OFF_ROLE:     if (clear_mode) role_r <= lane(role_r, wdata_r, wstrb_r);
                `CTS_OFF_BURST:    burst_r  <= lane(burst_r, wdata_r, wstrb_r);
                `CTS_OFF_DELAY:    delay_r  <= lane(delay_r, wdata_r, wstrb_r);
                default: ;
            endcase
        end
    end

    // Role only changes in clear mode to keep patterns consistent
    assign clear_mode = tx_multiplex_select_r == `CTS_MUX_CLEAR && rx_multiplex_select_r == `CTS_MUX_CLEAR;
    assign handset    = role_r[0];
    assign mux3_rx    = rx_multiplex_select_r[1:0] == `CTS_MUX_MUX3;

    // ==========================================================
    // Pattern choice: polarity by role; handset-sent marker in MUX3
    always_comb begin
        pattern = (rx_multiplex_select_r[1:0] == `CTS_MUX_MUX3) ? MARKER_BASE : ALIGN_BASE;
        if (handset ^ mux3_rx)
            pattern = ~pattern;
    end
    assign match = rx_multiplex_select_r[`CTS_RX_MULTIPLEX_SELECT_TOL] ?
                   (ones24(shift_r ^ pattern) <= 5'h01) : (shift_r == pattern);

    // Loop tracks when enabled or in base MUX3 receive; moves base timing only in MUX3 receive
    assign track_en = recov_r[`CTS_RC_ENABLE] || (!handset && mux3_rx);
    ctsync_dpll #(
        .BIT_CYC    (BIT_CYC)
    ) u_dpll (
        .clk        (CLK),
        .rst        (RST),
        .track_en   (track_en),
        .slow       (recov_r[`CTS_RC_SLOW] || found_r),
        .triple     (recov_r[`CTS_RC_TRIPLE]),
        .clear      (clear_mode),
        .rx_data    (RX_DATA),
        .bit_strobe (bit_strobe),
        .bit_value  (bit_value)
    );

    // ==========================================================
    // Frame search and lock
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            shift_r <= 24'h000000;
        end else if (clear_mode) begin
            shift_r <= 24'h000000;
        end else if (bit_strobe) begin
            shift_r <= {shift_r[22:0], bit_value};
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_r        <= CTS_CLEAR;
            bit_in_frame_r <= 12'h000;
            found_r        <= 1'b0;
        end else if (clear_mode) begin
            state_r <= CTS_CLEAR;
            found_r <= 1'b0;
        end else if (resync_cmd) begin
            state_r <= CTS_HUNT;
            found_r <= 1'b0;
        end else if (bit_strobe) begin
            case (state_r)
                CTS_CLEAR: state_r <= CTS_CLEAR;
                CTS_HUNT: begin
                    if (match) begin
                        state_r        <= CTS_LOCKED;
                        found_r        <= 1'b1;
                        bit_in_frame_r <= 12'h000;
                    end
                end
                CTS_LOCKED: begin
                    if (bit_in_frame_r == `CTS_FRAME_BITS - 12'h001)
                        bit_in_frame_r <= 12'h000;
                    else
                        bit_in_frame_r <= bit_in_frame_r + 12'h001;
                end
                default: state_r <= CTS_CLEAR;
            endcase
        end
    end

    // Causes: hardware set wins over a same-cycle software clear
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cause_r <= 8'h00;
        end else begin
            cause_r <= (wr_fire && awaddr_r == `CTS_OFF_CAUSE) ?
                       (cause_r & ~wdata_r[7:0]) : cause_r;
            if (bit_strobe && state_r == CTS_HUNT && match)
                cause_r[`CTS_CAUSE_FOUND] <= 1'b1;
            if (bit_strobe && state_r == CTS_LOCKED && !match
                && bit_in_frame_r == `CTS_FRAME_BITS - 12'h001)
                cause_r[`CTS_CAUSE_SYNERR] <= 1'b1;
        end
    end
    assign MARKER_IRQ = |(cause_r & mask_r);

    // ==========================================================
    // Link timing outputs
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            TX_ALLOW               <= 1'b0;
            RADIO_TIMING_FROM_LOOP <= 1'b0;
            REF_COUPLED            <= 1'b0;
        end else begin
            // Resync stops transmission; MUX1 waits for sync
            TX_ALLOW <= !clear_mode && !resync_cmd
                        && enable_r[3:`CTS_EN_FMT_LO] == `CTS_FMT_ON
                        && (state_r == CTS_LOCKED
                            || (tx_multiplex_select_r[1:0] != `CTS_MUX_MUX1 && !handset));
            RADIO_TIMING_FROM_LOOP <= handset ? (recov_r[`CTS_RC_ENABLE] && !mux3_rx)
                                              : mux3_rx;
            REF_COUPLED <= !handset && burst_r[7] && burst_r[6] && !mux3_rx
                           && enable_r[`CTS_EN_FRAME];
        end
    end

    // ==========================================================
    // Read channel
    assign ARREADY = !RVALID;
    assign RRESP   = 2'h0;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            RVALID <= 1'b0;
            RDATA  <= 32'h0000_0000;
        end else if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            case (ARADDR)
                `CTS_OFF_ENABLE:   RDATA <= {24'h0, enable_r};
                `CTS_OFF_TX_MULTIPLEX_SELECT:    RDATA <= {24'h0, tx_multiplex_select_r};
                `CTS_OFF_RX_MULTIPLEX_SELECT:    RDATA <= {24'h0, rx_multiplex_select_r};
                `CTS_OFF_RECOVERY: RDATA <= {24'h0, state_r == CTS_LOCKED, found_r,
                                             3'h0, recov_r[2:0]};
                `CTS_OFF_CAUSE:    RDATA <= {24'h0, cause_r};
                `CTS_OFF_MASK:     RDATA <= {24'h0, mask_r};
                `CTS_OFF_ROLE:     RDATA <= {24'h0, role_r};
                `CTS_OFF_BURST:    RDATA <= {24'h0, burst_r};
                `CTS_OFF_DELAY:    RDATA <= {24'h0, delay_r};
                default:           RDATA <= 32'h0000_0000;
            endcase
        end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: ctsync_monitor.sv
`include "ctsync_defines.svh"
`default_nettype none
module ctsync_monitor (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RST,
    // Register bus
    input wire logic [7:0]  AWADDR,
    input wire logic        AWVALID,
    input wire logic        AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic        WVALID,
    input wire logic        WREADY,
    input wire logic [1:0]  BRESP,
    input wire logic        BVALID,
    input wire logic        BREADY,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0]  RRESP,
    input wire logic        RVALID,
    input wire logic        RREADY,
    // Status
    input wire logic        TX_ALLOW,
    input wire logic        REF_COUPLED,
    input wire logic        MARKER_IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    wire wr_go = AWVALID && AWREADY && WVALID && WREADY;

    // ==========================================
    // Bus handshake
    chk_bvalid_hold: assert property (BVALID && !BREADY |=> BVALID)
        else $error("write response dropped early");
    chk_bvalid_done: assert property (BVALID && BREADY |=> !BVALID)
        else $error("write response held after accept");
    chk_rvalid_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read response changed before accept");
    chk_ar_refuse: assert property (RVALID |-> !ARREADY)
        else $error("read address taken while answer pending");
    chk_resp_okay: assert property ((BVALID |-> BRESP == 2'h0) and (RVALID |-> RRESP == 2'h0))
        else $error("response code not okay");
    chk_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read answer late");
    chk_write_answer: assert property (wr_go |-> ##2 BVALID)
        else $error("write answer late");

    // ==========================================
    // Link control
    // Allow one cycle for the command register before transmit drops
    chk_resync_stop: assert property (
        wr_go && AWADDR == `CTS_OFF_RESYNC |-> ##2 !TX_ALLOW)
        else $error("transmit still allowed after resync");
    chk_mux3_decouple: assert property (
        wr_go && AWADDR == `CTS_OFF_RX_MULTIPLEX_SELECT && WDATA[1:0] == 2'h3 |-> ##3 !REF_COUPLED)
        else $error("reference still coupled in mux3 receive");

    cover property (wr_go && AWADDR == `CTS_OFF_RESYNC);
    cover property ($rose(MARKER_IRQ));
    cover property ($fell(REF_COUPLED));
endmodule
`default_nettype wire

// File: ctsync_peer.sv
`default_nettype none
module ctsync_peer #(
    parameter logic [11:0] BIT_CYC = 12'd40,
    parameter logic [23:0] MARKER  = 24'h000000,
    parameter logic [23:0] ALIGN   = 24'h000000
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic en,
    input  wire logic flip,
    // Radio data
    output logic      rx_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] cyc_r;
    logic [7:0]  bit_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cyc_r <= 12'h000;
            bit_r <= 8'h00;
        end else if (cyc_r == BIT_CYC - 12'h001) begin
            cyc_r <= 12'h000;
            bit_r <= (bit_r == 8'd143) ? 8'h00 : bit_r + 8'h01;
        end else begin
            cyc_r <= cyc_r + 12'h001;
        end
    end

    // Idle line toggles every bit so a stale level never looks like data
    always_comb begin
        rx_data = bit_r[0];
        if (en && bit_r >= 8'd10 && bit_r < 8'd34) begin
            rx_data = MARKER[8'd33 - bit_r];
        end else if (en && bit_r >= 8'd60 && bit_r < 8'd84) begin
            rx_data = ALIGN[8'd83 - bit_r] ^ (flip && bit_r == 8'd70);
        end
    end
endmodule
`default_nettype wire

// File: ctsync_top_test.sv
`include "ctsync_defines.svh"
`default_nettype none
module ctsync_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] BC = 12'd40;
    localparam logic [23:0] MK = 24'hBEE4A1;
    localparam logic [23:0] AL = 24'h3E4E5F;
    localparam int          FR = 144 * 40;
    logic        CLK = 1'b0, RST = 1'b1;
    logic [7:0]  AWADDR = 8'h00, ARADDR = 8'h00;
    logic [31:0] WDATA = 32'h0, RDATA, v;
    logic [3:0]  WSTRB = 4'hF;
    logic [1:0]  BRESP, RRESP;
    logic        AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, RX_DATA, ok;
    logic        BURST_REF_PULSE = 0, peer_en = 0, peer_flip = 0;
    logic        TX_ALLOW, RADIO_TIMING_FROM_LOOP, REF_COUPLED, MARKER_IRQ;
    int          bad_count = 0, checked = 0;

    always #2.5 CLK = ~CLK;

    ctsync_top #(.MARKER_BASE(MK), .ALIGN_BASE(AL), .BIT_CYC(BC)) dut (.CLK, .RST,
        .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID,
        .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .RX_DATA,
        .BURST_REF_PULSE, .TX_ALLOW, .RADIO_TIMING_FROM_LOOP, .REF_COUPLED, .MARKER_IRQ);
    ctsync_peer #(.BIT_CYC(BC), .MARKER(MK), .ALIGN(AL)) peer (.clk(CLK), .rst(RST),
        .en(peer_en), .flip(peer_flip), .rx_data(RX_DATA));

    // ==========================================
    // Tasks
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Handshakes are judged at the falling edge, acted on at the next rise
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        b = 0;
        @(posedge CLK);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1;
        WVALID <= 1;
        BREADY <= 1;
        for (int n = 0; n < 100 && !b; n++) begin
            @(negedge CLK);
            aw = AWVALID && AWREADY;
            w = WVALID && WREADY;
            b = BVALID && BREADY;
            @(posedge CLK);
            if (aw) AWVALID <= 0;
            if (w) WVALID <= 0;
            if (b) BREADY <= 0;
        end
        if (!b) bad_count++;
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] exp);
        logic ar, r;
        r = 0;
        @(posedge CLK);
        ARADDR <= a;
        ARVALID <= 1;
        RREADY <= 1;
        for (int n = 0; n < 100 && !r; n++) begin
            @(negedge CLK);
            ar = ARVALID && ARREADY;
            r = RVALID && RREADY;
            if (r) v = RDATA;
            @(posedge CLK);
            if (ar) ARVALID <= 0;
            if (r) RREADY <= 0;
        end
        if (!r) bad_count++;
        chk(v, exp);
    endtask

    task wait_irq(input int lim);
        ok = 0;
        for (int i = 0; i < lim && !ok; i++) begin
            @(negedge CLK);
            ok = (MARKER_IRQ === 1'b1);
        end
        chk({31'h0, ok}, 32'h1);
    endtask

    task report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge CLK);
        bad_count++;
        report_and_stop();
    end

    // ==========================================
    // Tests
    initial begin
        repeat (12) @(posedge CLK);
        RST <= 0;
        rchk(`CTS_OFF_TX_MULTIPLEX_SELECT, 32'h3);
        rchk(`CTS_OFF_RX_MULTIPLEX_SELECT, 32'h3);
        rchk(`CTS_OFF_RECOVERY, 32'h0);
        rchk(`CTS_OFF_CAUSE, 32'h0);
        rchk(8'h40, 32'h0);
        $display("reset values done");
        wr(`CTS_OFF_BURST, 32'hC0);
        wr(`CTS_OFF_ENABLE, 32'h1C);
        wr(`CTS_OFF_RECOVERY, 32'h1);
        wr(`CTS_OFF_MASK, 32'h9);
        wr(`CTS_OFF_TX_MULTIPLEX_SELECT, 32'h2);
        wr(`CTS_OFF_RX_MULTIPLEX_SELECT, 32'h2);
        repeat (3) @(negedge CLK);
        chk({31'h0, REF_COUPLED}, 32'h1);
        chk({31'h0, RADIO_TIMING_FROM_LOOP}, 32'h0);
        wr(`CTS_OFF_ROLE, 32'h1);
        rchk(`CTS_OFF_ROLE, 32'h0);
        $display("base setup done");
        wr(`CTS_OFF_TX_MULTIPLEX_SELECT, 32'h0);
        peer_en <= 1;
        wr(`CTS_OFF_RESYNC, 32'h1);
        @(negedge CLK);
        chk({31'h0, TX_ALLOW}, 32'h0);
        wait_irq(3 * FR);
        rchk(`CTS_OFF_CAUSE, 32'h1);
        rchk(`CTS_OFF_RECOVERY, 32'hC1);
        wr(`CTS_OFF_CAUSE, 32'h1);
        rchk(`CTS_OFF_CAUSE, 32'h0);
        peer_en <= 0;
        wait_irq(2 * FR);
        rchk(`CTS_OFF_CAUSE, 32'h8);
        $display("lock and loss done");
        wr(`CTS_OFF_CAUSE, 32'h9);
        wr(`CTS_OFF_RX_MULTIPLEX_SELECT, 32'hA);
        peer_flip <= 1;
        peer_en <= 1;
        wr(`CTS_OFF_RESYNC, 32'h1);
        wait_irq(3 * FR);
        rchk(`CTS_OFF_CAUSE, 32'h1);
        $display("error tolerance done");
        wr(`CTS_OFF_RX_MULTIPLEX_SELECT, 32'h3);
        repeat (3) @(negedge CLK);
        chk({31'h0, REF_COUPLED}, 32'h0);
        wr(`CTS_OFF_RX_MULTIPLEX_SELECT, 32'h2);
        repeat (3) @(negedge CLK);
        chk({31'h0, REF_COUPLED}, 32'h1);
        wr(`CTS_OFF_TX_MULTIPLEX_SELECT, 32'h3);
        wr(`CTS_OFF_RX_MULTIPLEX_SELECT, 32'h3);
        wr(`CTS_OFF_ROLE, 32'h1);
        rchk(`CTS_OFF_ROLE, 32'h1);
        $display("mux and clear done");
        report_and_stop();
    end
endmodule

bind ctsync_top ctsync_monitor mon (.CLK, .RST, .AWADDR, .AWVALID, .AWREADY, .WDATA,
    .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARVALID, .ARREADY, .RDATA, .RRESP,
    .RVALID, .RREADY, .TX_ALLOW, .REF_COUPLED, .MARKER_IRQ);
`default_nettype wire
